//--- hdl/cmd_decoder_defs.vh
// Behaviour
// - Select high: low byte is command code
// - Dataless commands execute on command receipt
// - Select low: data moves for last command
// - Wide registers go least significant first
// - 16-bit: ignore high lane, undefined bytes
// - Odd IN count: final high byte unsent
// - Buffer starts with two-byte packet count
// - 20h-2Fh write endpoint configuration byte
// - 30h-3Fh read endpoint configuration byte
// - 01h-0Fh fill IN FIFOs, size limited
// - 10h,12h-1Fh read OUT FIFOs, no size limit
// - 40h-4Fh stall, 80h-8Fh unstall, no data
// - 50h-5Fh read endpoint status byte
// - D0h-DFh status copy, nothing cleared
// - 6xh validate IN, 7xh clear OUT buffers
// - F4h acknowledges setup on both control endpoints
// - A0h-AFh read endpoint error code
// - B0h plus two bytes unlocks writes
// - Unlock succeeds only with AA37h
// - After wake, writes blocked until unlock
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH

// ----------------------------------------------------------------
// Command groups (upper nibble) and single codes
// ----------------------------------------------------------------
`define GRP_IN_WR     4'h0
`define GRP_OUT_RD    4'h1
`define GRP_CFG_WR    4'h2
`define GRP_CFG_RD    4'h3
`define GRP_STALL     4'h4
`define GRP_STAT      4'h5
`define GRP_VALID     4'h6
`define GRP_CLEAR     4'h7
`define GRP_UNSTALL   4'h8
`define GRP_ERR       4'ha
`define GRP_GEN       4'hb
`define GRP_CHECK     4'hd
`define GRP_SPECIAL   4'hf
`define CODE_UNLOCK   8'hb0
`define CODE_ACK_SET  8'hf4
`define EP_CTRL_OUT   4'h0
`define EP_CTRL_IN    4'h1

// ----------------------------------------------------------------
// Framing and limits
// ----------------------------------------------------------------
`define UNLOCK_KEY    16'haa37
`define LIM_BULK      16'h0040
`define LIM_ISO       16'h03ff
`define CFG_ISO_BIT   4
`define CNT_W         10
`define HDR_WORDS     2'h1
`define HDR_BYTES     2'h2

// ----------------------------------------------------------------
// Event kinds
// ----------------------------------------------------------------
`define EV_VALIDATE   2'h0
`define EV_CLEAR      2'h1
`define EV_ACK_SETUP  2'h2
`define EV_STAT_READ  2'h3

`endif

//--- hdl/ep_cfg_mem.v
`timescale 1ns/10ps
`default_nettype none
module ep_cfg_mem #(
   parameter AW = 4,
   parameter W  = 8
) (
   input  wire          clock_i,
   input  wire          rstn_i,
   input  wire          ce_i,
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [W-1:0]  wdata_i,
   input  wire [AW-1:0] raddr_i,
   output reg  [W-1:0]  rdata_o
);
   reg     [W-1:0] mem_r [0:(1<<AW)-1];
   integer         i;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (i = 0; i < (1<<AW); i = i + 1) begin
            mem_r[i] <= {W{1'b0}};
         end
         rdata_o <= {W{1'b0}};
      end else if (ce_i) begin
         if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
         end
         rdata_o <= mem_r[raddr_i];
      end
   end
endmodule
`default_nettype wire

//--- hdl/sync_fifo.v
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
   parameter W     = 22,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire         clock_i,
   input  wire         rstn_i,
   input  wire         ce_i,
   input  wire         s_valid_i,
   input  wire [W-1:0] s_data_i,
   output reg          s_ready_o,
   output reg          m_valid_o,
   output reg  [W-1:0] m_data_o,
   input  wire         m_ready_i
);
   reg [W-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0]   cnt_r;
   reg [AW:0]   cnt_nxt;
   wire         push;
   wire         load;
   wire         vld_nxt;

   assign push = s_valid_i & s_ready_o;
   assign load = (cnt_r != {(AW+1){1'b0}}) & (~m_valid_o | m_ready_i);
   assign vld_nxt = load | (m_valid_o & ~m_ready_i);

   always @* begin
      cnt_nxt = cnt_r;
      if (push & ~load) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (load & ~push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // Output stage is a register so the consumer never sees array read paths
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_r      <= {AW{1'b0}};
         rp_r      <= {AW{1'b0}};
         cnt_r     <= {(AW+1){1'b0}};
         s_ready_o <= 1'b1;
         m_valid_o <= 1'b0;
         m_data_o  <= {W{1'b0}};
      end else if (ce_i) begin
         if (push) begin
            mem_r[wp_r] <= s_data_i;
            wp_r        <= wp_r + 1'b1;
         end
         if (load) begin
            m_data_o  <= mem_r[rp_r];
            m_valid_o <= 1'b1;
            rp_r      <= rp_r + 1'b1;
         end else if (m_ready_i) begin
            m_valid_o <= 1'b0;
         end
         cnt_r     <= cnt_nxt;
         // Output register counts toward the depth
         s_ready_o <= ((cnt_nxt + {{AW{1'b0}}, vld_nxt}) < DEPTH[AW:0]);
      end
   end
endmodule
`default_nettype wire

//--- hdl/usb_device_command_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "cmd_decoder_defs.vh"
module usb_device_command_decoder #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW    = 4
) (
   input  wire         clock_i,
   input  wire         rstn_i,
   input  wire         ce_i,
   input  wire         cs_n_i,
   input  wire         wr_n_i,
   input  wire         rd_n_i,
   input  wire         command_data_select_i,
   input  wire         bus16_i,
   input  wire [15:0]  data_i,
   output reg  [15:0]  data_o,
   output reg          data_oe_o,
   input  wire         wake_lock_i,
   output reg          locked_o,
   output reg  [15:0]  stall_o,
   output reg          ev_valid_o,
   output reg  [1:0]   ev_kind_o,
   output reg  [3:0]   ev_ep_o,
   output wire         in_ready_o,
   output wire         tx_valid_o,
   input  wire         tx_ready_i,
   output wire [15:0]  tx_data_o,
   output wire [3:0]   tx_ep_o,
   output wire         tx_last_o,
   output wire         tx_hi_valid_o,
   input  wire [15:0]  rx_data_i,
   output reg          rx_pop_o,
   input  wire [127:0] ep_status_i,
   input  wire [127:0] err_code_i
);
   // ----------------------------------------------------------------
   // Data phase states
   // ----------------------------------------------------------------
   localparam PH_NONE = 4'h0;
   localparam PH_INW  = 4'h1;
   localparam PH_OUTR = 4'h2;
   localparam PH_CFGW = 4'h3;
   localparam PH_CFGR = 4'h4;
   localparam PH_STAT = 4'h5;
   localparam PH_ERR  = 4'h6;
   localparam PH_CHK  = 4'h7;
   localparam PH_UNLK = 4'h8;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg  [20:0] meta_r;
   reg  [20:0] pins_r;
   reg         wr_prev_r;
   reg         rd_prev_r;
   wire [15:0] d_s;
   wire        rd_s;
   wire        wr_s;
   wire        cs_s;
   wire        a0_s;
   wire        b16_s;

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= 21'h070000;
         pins_r <= 21'h070000;
      end else if (ce_i) begin
         meta_r <= {bus16_i, command_data_select_i, cs_n_i, wr_n_i, rd_n_i, data_i};
         pins_r <= meta_r;
      end
   end

   assign d_s   = pins_r[15:0];
   assign rd_s  = pins_r[16];
   assign wr_s  = pins_r[17];
   assign cs_s  = pins_r[18];
   assign a0_s  = pins_r[19];
   assign b16_s = pins_r[20];

   // Strobes act at the write's trailing edge, so data is settled by then
   wire wr_end   = ~cs_s & wr_s & ~wr_prev_r;
   wire rd_start = ~cs_s & ~rd_s & rd_prev_r;
   wire rd_end   = rd_s & ~rd_prev_r;
   wire cmd_wr   = wr_end & a0_s;
   wire dat_wr   = wr_end & ~a0_s;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [3:0]  phase_r;
   reg  [3:0]  ep_r;
   reg  [1:0]  idx_r;
   reg  [7:0]  lo_byte_r;
   reg  [9:0]  rem_r;
   reg         push_r;
   reg  [21:0] push_data_r;
   reg         cfg_we_r;
   reg  [7:0]  cfg_wdata_r;
   reg         rd_act_r;
   wire [7:0]  cfg_rdata;
   wire [7:0]  code     = d_s[7:0];
   wire [7:0]  stat_b   = ep_status_i[{ep_r, 3'h0} +: 8];
   wire [7:0]  err_b    = err_code_i[{ep_r, 3'h0} +: 8];
   wire [15:0] limit    = cfg_rdata[`CFG_ISO_BIT] ? `LIM_ISO : `LIM_BULK;
   wire [1:0]  hdr_len  = b16_s ? `HDR_WORDS : `HDR_BYTES;
   wire        hdr_done = (idx_r >= hdr_len);
   wire [15:0] cnt_raw  = b16_s ? d_s : {d_s[7:0], lo_byte_r};
   wire [9:0]  cnt_lim  = (cnt_raw > limit) ? limit[9:0] : cnt_raw[9:0];
   wire        two_b    = b16_s & (rem_r > 10'h001);
   wire [9:0]  take     = two_b ? 10'h002 : 10'h001;
   wire [15:0] key      = b16_s ? d_s : {d_s[7:0], lo_byte_r};

   // ----------------------------------------------------------------
   // Command and data phase handling
   // ----------------------------------------------------------------
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_r     <= PH_NONE;
         ep_r        <= 4'h0;
         idx_r       <= 2'h0;
         lo_byte_r   <= 8'h00;
         rem_r       <= 10'h000;
         push_r      <= 1'b0;
         push_data_r <= 22'h000000;
         cfg_we_r    <= 1'b0;
         cfg_wdata_r <= 8'h00;
         locked_o    <= 1'b0;
         stall_o     <= 16'h0000;
         ev_valid_o  <= 1'b0;
         ev_kind_o   <= 2'h0;
         ev_ep_o     <= 4'h0;
         wr_prev_r   <= 1'b1;
         rd_prev_r   <= 1'b1;
      end else if (ce_i) begin
         wr_prev_r  <= wr_s;
         rd_prev_r  <= rd_s;
         push_r     <= 1'b0;
         cfg_we_r   <= 1'b0;
         ev_valid_o <= 1'b0;
         if (cmd_wr) begin
            ep_r    <= code[3:0];
            idx_r   <= 2'h0;
            phase_r <= PH_NONE;
            case (code[7:4])
               `GRP_IN_WR: begin
                  if (code[3:0] != `EP_CTRL_OUT) begin
                     phase_r <= PH_INW;
                  end
               end
               `GRP_OUT_RD: begin
                  if (code[3:0] != `EP_CTRL_IN) begin
                     phase_r <= PH_OUTR;
                  end
               end
               `GRP_CFG_WR: phase_r <= PH_CFGW;
               `GRP_CFG_RD: phase_r <= PH_CFGR;
               `GRP_STAT:   phase_r <= PH_STAT;
               `GRP_ERR:    phase_r <= PH_ERR;
               `GRP_CHECK:  phase_r <= PH_CHK;
               `GRP_STALL: begin
                  if (!locked_o) begin
                     stall_o[code[3:0]] <= 1'b1;
                  end
               end
               `GRP_UNSTALL: begin
                  if (!locked_o) begin
                     stall_o[code[3:0]] <= 1'b0;
                  end
               end
               `GRP_VALID: begin
                  if (code[3:0] != `EP_CTRL_OUT) begin
                     ev_valid_o <= 1'b1;
                     ev_kind_o  <= `EV_VALIDATE;
                     ev_ep_o    <= code[3:0];
                  end
               end
               `GRP_CLEAR: begin
                  if (code[3:0] != `EP_CTRL_IN) begin
                     ev_valid_o <= 1'b1;
                     ev_kind_o  <= `EV_CLEAR;
                     ev_ep_o    <= code[3:0];
                  end
               end
               `GRP_GEN: begin
                  if (code == `CODE_UNLOCK) begin
                     phase_r <= PH_UNLK;
                  end
               end
               `GRP_SPECIAL: begin
                  if (code == `CODE_ACK_SET) begin
                     ev_valid_o <= 1'b1;
                     ev_kind_o  <= `EV_ACK_SETUP;
                     ev_ep_o    <= code[3:0];
                  end
               end
               default: phase_r <= PH_NONE;
            endcase
         end else if (dat_wr) begin
            if (idx_r != 2'h3) begin
               idx_r <= idx_r + 2'h1;
            end
            case (phase_r)
               PH_CFGW: begin
                  if (idx_r == 2'h0 && !locked_o) begin
                     cfg_we_r    <= 1'b1;
                     cfg_wdata_r <= d_s[7:0];
                  end
               end
               PH_UNLK: begin
                  if (idx_r == 2'h0 && !b16_s) begin
                     lo_byte_r <= d_s[7:0];
                  end else if (idx_r == hdr_len - 2'h1) begin
                     if (key == `UNLOCK_KEY) begin
                        locked_o <= 1'b0;
                     end
                  end
               end
               PH_INW: begin
                  if (!hdr_done) begin
                     if (idx_r == 2'h0 && !b16_s) begin
                        lo_byte_r <= d_s[7:0];
                     end else begin
                        rem_r <= cnt_lim;
                     end
                  end else if (rem_r != 10'h000 && !locked_o) begin
                     push_r      <= 1'b1;
                     rem_r       <= rem_r - take;
                     // Byte lane above an odd tail is never sent
                     push_data_r <= {ep_r, (rem_r <= take), two_b,
                                     two_b ? d_s[15:8] : 8'h00,
                                     d_s[7:0]};
                  end
               end
               default: begin
               end
            endcase
         end
         if (rd_end && rd_act_r && phase_r == PH_STAT && idx_r == 2'h0) begin
            ev_valid_o <= 1'b1;
            ev_kind_o  <= `EV_STAT_READ;
            ev_ep_o    <= ep_r;
         end
         if (rd_end && rd_act_r && idx_r != 2'h3) begin
            idx_r <= idx_r + 2'h1;
         end
         // Wake beats an unlock landing in the same cycle
         if (wake_lock_i) begin
            locked_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   reg [15:0] rd_word;

   always @* begin
      rd_word = 16'h0000;
      case (phase_r)
         PH_CFGR: rd_word = {8'h00, cfg_rdata};
         PH_STAT: rd_word = {8'h00, stat_b};
         PH_CHK:  rd_word = {8'h00, stat_b};
         PH_ERR:  rd_word = {8'h00, err_b};
         PH_OUTR: begin
            if (b16_s) begin
               rd_word = rx_data_i;
            end else if (idx_r[0]) begin
               rd_word = {8'h00, rx_data_i[15:8]};
            end else begin
               rd_word = {8'h00, rx_data_i[7:0]};
            end
         end
         default: rd_word = 16'h0000;
      endcase
   end

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_o    <= 16'h0000;
         data_oe_o <= 1'b0;
         rd_act_r  <= 1'b0;
         rx_pop_o  <= 1'b0;
      end else if (ce_i) begin
         data_oe_o <= ~cs_s & ~rd_s;
         rx_pop_o  <= 1'b0;
         if (rd_start) begin
            data_o   <= rd_word;
            rd_act_r <= 1'b1;
         end else if (rd_end) begin
            rd_act_r <= 1'b0;
            // A word leaves the receive side once both lanes were read, or at each byte read after the fourth
            if (rd_act_r && phase_r == PH_OUTR && (b16_s || idx_r[0])) begin
               rx_pop_o <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration store and transmit buffer
   // ----------------------------------------------------------------
   ep_cfg_mem #(
      .AW (4),
      .W  (8)
   ) u_cfg (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .ce_i    (ce_i),
      .we_i    (cfg_we_r),
      .waddr_i (ep_r),
      .wdata_i (cfg_wdata_r),
      .raddr_i (ep_r),
      .rdata_o (cfg_rdata)
   );

   wire [21:0] tx_word;

   sync_fifo #(
      .W     (22),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .s_valid_i (push_r),
      .s_data_i  (push_data_r),
      .s_ready_o (in_ready_o),
      .m_valid_o (tx_valid_o),
      .m_data_o  (tx_word),
      .m_ready_i (tx_ready_i)
   );

   assign tx_ep_o       = tx_word[21:18];
   assign tx_last_o     = tx_word[17];
   assign tx_hi_valid_o = tx_word[16];
   assign tx_data_o     = tx_word[15:0];
endmodule
`default_nettype wire

//--- sim/cmd_chk_checker.sv
`timescale 1ns/10ps
`default_nettype none
module cmd_chk (
   input wire logic        clock_i,
   input wire logic        rstn_i,
   input wire logic        cs_n_i,
   input wire logic        rd_n_i,
   input wire logic        wake_lock_i,
   input wire logic        tx_ready_i,
   input wire logic        bus16_i,
   input wire logic [15:0] stall_o,
   input wire logic        data_oe_o,
   input wire logic        locked_o,
   input wire logic        ev_valid_o,
   input wire logic [1:0]  ev_kind_o,
   input wire logic [3:0]  ev_ep_o,
   input wire logic        rx_pop_o,
   input wire logic        tx_valid_o,
   input wire logic [15:0] tx_data_o,
   input wire logic        tx_last_o,
   input wire logic        tx_hi_valid_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ---------------------------------------------
   // Sequences
   // ---------------------------------------------
   sequence s_no_read; (cs_n_i || rd_n_i) [*5]; endsequence
   sequence s_cs_idle; cs_n_i [*8]; endsequence
   sequence s_tx_stuck; tx_valid_o && !tx_ready_i; endsequence
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   property p_oe_idle; s_no_read |-> !data_oe_o; endproperty
   property p_ev_pulse; ev_valid_o |=> !ev_valid_o; endproperty
   property p_ev_hold; !ev_valid_o |-> $stable(ev_kind_o) && $stable(ev_ep_o); endproperty
   property p_rx_pulse; rx_pop_o |=> !rx_pop_o; endproperty
   property p_tx_hold;
      s_tx_stuck |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
   endproperty
   property p_tx_odd; tx_valid_o && !tx_last_o && bus16_i |-> tx_hi_valid_o; endproperty
   property p_lock_set; wake_lock_i |=> locked_o; endproperty
   property p_stall_lock; locked_o |=> $stable(stall_o); endproperty
   // Stall bits hold and no event fires once chip select has been idle for 8 cycles
   property p_cs_idle; s_cs_idle |=> $stable(stall_o) && !ev_valid_o; endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("bus driven without a read");
   a_ev_pulse: assert property (p_ev_pulse)
      else $error("event longer than one cycle");
   a_ev_hold: assert property (p_ev_hold)
      else $error("event fields moved without event");
   a_rx_pulse: assert property (p_rx_pulse)
      else $error("receive pop longer than one cycle");
   a_tx_hold: assert property (p_tx_hold)
      else $error("transmit word dropped while stalled");
   a_tx_odd: assert property (p_tx_odd)
      else $error("high byte dropped before last word");
   a_lock_set: assert property (p_lock_set)
      else $error("wake did not lock writes");
   a_stall_lock: assert property (p_stall_lock)
      else $error("stall changed while locked");
   a_cs_idle: assert property (p_cs_idle)
      else $error("action without chip select");
endmodule
bind usb_device_command_decoder cmd_chk cmd_chk_inst (.clock_i(clock_i), .rstn_i(rstn_i),
   .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wake_lock_i(wake_lock_i), .tx_ready_i(tx_ready_i),
   .stall_o(stall_o), .data_oe_o(data_oe_o), .locked_o(locked_o), .ev_valid_o(ev_valid_o),
   .ev_kind_o(ev_kind_o), .ev_ep_o(ev_ep_o), .rx_pop_o(rx_pop_o), .tx_valid_o(tx_valid_o),
   .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_hi_valid_o(tx_hi_valid_o),
   .bus16_i(bus16_i));
`default_nettype wire

//--- sim/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model #(
   parameter HOLD = 4
) (
   input  wire logic        clock_i,
   input  wire logic [15:0] rdata_i,
   output var logic         cs_n_o,
   output var logic         wr_n_o,
   output var logic         rd_n_o,
   output var logic         sel_o,
   output var logic [15:0]  data_o
);
   initial begin
      cs_n_o = 1'b1;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      sel_o = 1'b0;
      data_o = 16'h0000;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // Whole words only; a byte lane is never written alone
   task automatic wr(input logic sel, input logic [15:0] d);
      @(negedge clock_i);
      cs_n_o = 1'b0;
      sel_o = sel;
      data_o = d;
      wr_n_o = 1'b0;
      gap(HOLD);
      wr_n_o = 1'b1;
      gap(HOLD);
      cs_n_o = 1'b1;
      data_o = ~d; // Released lines never repeat the old value
      gap(HOLD);
   endtask
   // Sampled late enough to cover the pin synchronisers
   task automatic rd(output logic [15:0] q);
      @(negedge clock_i);
      cs_n_o = 1'b0;
      sel_o = 1'b0;
      rd_n_o = 1'b0;
      gap(HOLD + 3);
      q = rdata_i;
      rd_n_o = 1'b1;
      gap(HOLD);
      cs_n_o = 1'b1;
      gap(HOLD);
   endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic bus16_i = 1'b0;
   logic wake_lock_i = 1'b0;
   logic tx_ready_i = 1'b0;
   logic [127:0] ep_status_i;
   logic [127:0] err_code_i;
   logic [15:0] rx_mem [0:3];
   logic [21:0] txq [$];
   logic [1:0] ev_k = 2'h0;
   logic [3:0] ev_e = 4'h0;
   logic [15:0] r;
   int rx_idx = 0;
   int ev_cnt = 0;
   int cyc = 0;
   int fail_count = 0;
   int cmp_count = 0;
   wire cs_n, wr_n, rd_n, sel, data_oe_o, locked_o, ev_valid_o, in_ready_o;
   wire tx_valid_o, tx_last_o, tx_hi_valid_o, rx_pop_o;
   wire [15:0] hdata, data_o, stall_o, tx_data_o;
   wire [1:0] ev_kind_o;
   wire [3:0] ev_ep_o, tx_ep_o;
   wire [15:0] bus = data_oe_o ? data_o : hdata;
   wire [15:0] rx_data_i = rx_mem[rx_idx[1:0]];
   host_model host_model_inst (.clock_i(clock_i), .rdata_i(bus), .cs_n_o(cs_n),
      .wr_n_o(wr_n), .rd_n_o(rd_n), .sel_o(sel), .data_o(hdata));
   usb_device_command_decoder usb_device_command_decoder_inst (.clock_i(clock_i),
      .rstn_i(rstn_i), .ce_i(1'b1), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
      .command_data_select_i(sel), .bus16_i(bus16_i), .data_i(bus), .data_o(data_o),
      .data_oe_o(data_oe_o), .wake_lock_i(wake_lock_i), .locked_o(locked_o),
      .stall_o(stall_o), .ev_valid_o(ev_valid_o), .ev_kind_o(ev_kind_o), .ev_ep_o(ev_ep_o),
      .in_ready_o(in_ready_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .tx_data_o(tx_data_o), .tx_ep_o(tx_ep_o), .tx_last_o(tx_last_o),
      .tx_hi_valid_o(tx_hi_valid_o), .rx_data_i(rx_data_i), .rx_pop_o(rx_pop_o),
      .ep_status_i(ep_status_i), .err_code_i(err_code_i));
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   // ---------------------------------------------
   // Monitors and helpers
   // ---------------------------------------------
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (rx_pop_o === 1'b1) rx_idx <= rx_idx + 1;
      if (ev_valid_o === 1'b1) begin
         ev_cnt <= ev_cnt + 1;
         ev_k <= ev_kind_o;
         ev_e <= ev_ep_o;
      end
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
         txq.push_back({tx_last_o, tx_hi_valid_o, tx_ep_o, tx_data_o});
      if (cyc == 20000) begin
         fail_count++;
         summarize();
      end
   end
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task cmd(input logic [15:0] c); host_model_inst.wr(1'b1, c); endtask
   task dat(input logic [15:0] d); host_model_inst.wr(1'b0, d); endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_cfg;
      cmd(16'h7720);
      dat(16'h00a5);
      cmd(16'h002f);
      dat(16'h005a);
      cmd(16'h0030);
      host_model_inst.rd(r);
      chk(r, 16'h00a5, "config ctrl out");
      cmd(16'h003f);
      host_model_inst.rd(r);
      chk(r, 16'h005a, "config last ep");
   endtask
   task t_stall;
      for (int i = 0; i < 16; i++) cmd(16'h0040 + 16'(i));
      chk(stall_o, 16'hffff, "all stalled");
      for (int i = 0; i < 16; i++) cmd(16'h0080 + 16'(i));
      chk(stall_o, 16'h0000, "all unstalled");
   endtask
   task t_events;
      logic [7:0] code [5] = '{8'h61, 8'h6f, 8'h70, 8'h7f, 8'hf4};
      logic [1:0] kind [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
      int n;
      for (int i = 0; i < 5; i++) begin
         n = ev_cnt;
         cmd({8'h00, code[i]});
         chk(ev_cnt, n + 1, "one event");
         chk(ev_k, kind[i], "event kind");
         if (i < 4) chk(ev_e, code[i][3:0], "event endpoint");
      end
   endtask
   task t_status;
      int n;
      n = ev_cnt;
      cmd(16'h0053);
      host_model_inst.rd(r);
      chk(r, 16'h0083, "status byte");
      chk({ev_cnt, ev_k, ev_e}, {n + 1, 2'h3, 4'h3}, "status event");
      cmd(16'h00d3);
      host_model_inst.rd(r);
      chk(r, 16'h0083, "status copy");
      chk(ev_cnt, n + 1, "copy leaves status");
      cmd(16'h00a4);
      host_model_inst.rd(r);
      chk(r, 16'h00c4, "error code");
   endtask
   task t_lock;
      wake_lock_i = 1'b1;
      @(negedge clock_i);
      wake_lock_i = 1'b0;
      @(negedge clock_i);
      chk(locked_o, 1'b1, "locked after wake");
      cmd(16'h0046);
      cmd(16'h0025);
      dat(16'h0077);
      chk(stall_o[6], 1'b0, "stall blocked");
      cmd(16'h00b0);
      dat(16'h0036);
      dat(16'h00aa);
      chk(locked_o, 1'b1, "wrong key refused");
      cmd(16'h00b0);
      dat(16'h0037);
      dat(16'h00aa);
      chk(locked_o, 1'b0, "unlocked");
      cmd(16'h0035);
      host_model_inst.rd(r);
      chk(r, 16'h0000, "config write blocked");
      cmd(16'h0046);
      chk(stall_o[6], 1'b1, "stall after unlock");
      cmd(16'h0086);
   endtask
   task t_illegal;
      // Unlisted codes only; host keeps off illegal directions
      logic [7:0] code [6] = '{8'h90, 8'hc5, 8'he1, 8'hf5, 8'hb1, 8'h9e};
      int n;
      n = ev_cnt;
      for (int i = 0; i < 6; i++) begin
         cmd({8'h00, code[i]});
         dat(16'h0066);
      end
      chk({ev_cnt, stall_o, tx_valid_o}, {n, 16'h0000, 1'b0}, "no action");
      cmd(16'h0030);
      host_model_inst.rd(r);
      chk(r, 16'h00a5, "config kept");
   endtask
   task t_out;
      cmd(16'h0010);
      host_model_inst.rd(r);
      chk(r, 16'h0003, "count low byte");
      host_model_inst.rd(r);
      chk({r, rx_idx[7:0]}, {16'h0000, 8'h01}, "count high byte");
      bus16_i = 1'b1;
      cmd(16'h5a12);
      host_model_inst.rd(r);
      chk(r, 16'h2211, "out word");
      host_model_inst.rd(r);
      chk(r[7:0], 8'h33, "odd last word");
      chk(rx_idx, 3, "pops");
   endtask
   task t_in;
      tx_ready_i = 1'b1;
      chk(in_ready_o, 1'b1, "room");
      cmd(16'h0003);
      dat(16'h0003);
      dat(16'h2211);
      dat(16'hee33);
      repeat (5) @(negedge clock_i);
      chk(txq.size(), 2, "word count");
      chk(txq.pop_front(), {2'b01, 4'h3, 16'h2211}, "first word");
      r = txq[0][15:0];
      chk({txq.pop_front() >> 16, r[7:0]}, {6'b100011, 8'h33}, "odd tail");
   endtask
   task t_fill;
      tx_ready_i = 1'b0;
      cmd(16'h0004);
      dat(16'h0022);
      for (int i = 0; i < 17; i++) dat(16'h0100 + 16'(i));
      chk(in_ready_o, 1'b0, "fifo full");
      tx_ready_i = 1'b1;
      repeat (40) @(negedge clock_i);
      chk({txq.size(), in_ready_o}, {32'd16, 1'b1}, "drained");
      for (int i = 0; i < 16; i++)
         chk(txq.pop_front() & 22'h0fffff, {4'h4, 16'h0100 + 16'(i)}, "fifo order");
   endtask
   initial begin
      for (int i = 0; i < 16; i++) begin
         ep_status_i[8*i +: 8] = 8'h80 + 8'(i);
         err_code_i[8*i +: 8] = 8'hc0 + 8'(i);
      end
      rx_mem = '{16'h0003, 16'h2211, 16'hee33, 16'h0000};
      repeat (16) @(negedge clock_i);
      rstn_i = 1'b1;
      @(negedge clock_i);
      t_cfg();
      t_stall();
      t_events();
      t_status();
      t_lock();
      t_illegal();
      t_out();
      t_in();
      t_fill();
      summarize();
   end
endmodule
`default_nettype wire
